// ---- design/gate_defines.svh ----
// Constants for the deep-sleep clock gating block
`ifndef GATE_DEFINES_SVH
`define GATE_DEFINES_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define DEEP_GATE_OFF 12'h120
`define RUN_GATE_OFF 12'h124
`define SLEEP_GATE_OFF 12'h128
`define CLK_CONFIG_OFF 12'h12C

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define WATCHDOG_BIT 3
`define KEEPER_BIT 6
`define CONV_BIT 16
`define PWM_BIT 20
`define FIELDBUS_BIT 24
`define GATE_MASK 32'h01110048
`define GATE_RESET 32'h00000040
`define GATE_RESET_PACKED 5'h02
`define SEL_BIT 0
`define NUM_UNITS 5

`endif

// ---- design/gate_pkg.sv ----
// Types for the deep-sleep clock gating block
package gate_pkg;

   typedef enum logic [1:0] {
      PWR_RUN = 2'b00,
      PWR_SLEEP = 2'b01,
      PWR_DEEP = 2'b10
   } pwr_e;

   typedef struct packed {
      logic [4:0] run_gate;
      logic [4:0] sleep_gate;
      logic [4:0] deep_gate;
      logic sel;
      logic [4:0] unit_en;
      logic [31:0] prdata;
   } gate_state_s;

endpackage : gate_pkg

// ---- design/glitch_free_gate.sv ----
// Latch-based clock gating cell
`timescale 1ns/1ps
module glitch_free_gate (
   // Clock in
   input wire logic clk_in,
   // Enable from the register side
   input wire logic enable,
   // Gated clock
   output logic clk_out
);

   logic en_latched;

   // Enable only moves while the clock is low, so no short pulse
   always_latch begin
      if (!clk_in) begin
         en_latched <= enable;
      end
   end

   assign clk_out = clk_in & en_latched;

endmodule : glitch_free_gate

// ---- design/deep_sleep_clock_gate_reg0.sv ----
// APB clock gating registers with per-unit gated clocks
`timescale 1ns/1ps
`include "gate_defines.svh"
module deep_sleep_clock_gate_reg0 (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Current power state from the processor
   input wire logic [1:0] pwr_state,
   // Peripheral bus access to gated units
   input wire logic unit_access,
   input wire logic [4:0] unit_sel,
   output logic unit_fault,
   // Unit clocks: 0 watchdog, 1 keeper, 2 conv, 3 pwm, 4 fieldbus
   output logic [4:0] unit_clk_en,
   output logic [4:0] unit_clk
);

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   function automatic logic [31:0] to_word(input logic [4:0] g);
      logic [31:0] w;
      w = 32'h00000000;
      w[`WATCHDOG_BIT] = g[0];
      w[`KEEPER_BIT] = g[1];
      w[`CONV_BIT] = g[2];
      w[`PWM_BIT] = g[3];
      w[`FIELDBUS_BIT] = g[4];
      return w;
   endfunction : to_word

   function automatic logic [4:0] to_gate(input logic [31:0] w);
      logic [4:0] g;
      g = {w[`FIELDBUS_BIT], w[`PWM_BIT], w[`CONV_BIT],
           w[`KEEPER_BIT], w[`WATCHDOG_BIT]};
      return g;
   endfunction : to_gate

   function automatic logic addr_hit(input logic [11:0] a);
      logic h;
      h = (a == `DEEP_GATE_OFF) || (a == `RUN_GATE_OFF) ||
          (a == `SLEEP_GATE_OFF) || (a == `CLK_CONFIG_OFF);
      return h;
   endfunction : addr_hit

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   gate_pkg::gate_state_s st_ff;
   gate_pkg::gate_state_s nxt_st;
   gate_pkg::pwr_e pwr;
   logic setup_ph;
   logic access_ph;
   logic wr_en;
   logic [4:0] wr_gate;
   logic [4:0] active_en;
   logic [31:0] rd_word;

   assign pwr = gate_pkg::pwr_e'(pwr_state);
   assign setup_ph = psel & ~penable;
   assign access_ph = psel & penable;
   // Zero wait states; the slave is always ready
   assign pready = 1'b1;
   assign wr_en = access_ph & pwrite & addr_hit(paddr);
   // Reserved bits are dropped on write, so they read back zero
   assign wr_gate = to_gate(pwdata);

   // ------------------------------------------------------------
   // Gating source selection
   // ------------------------------------------------------------
   always_comb begin
      active_en = st_ff.run_gate;
      if (st_ff.sel) begin
         unique case (pwr)
            gate_pkg::PWR_RUN: active_en = st_ff.run_gate;
            gate_pkg::PWR_SLEEP: active_en = st_ff.sleep_gate;
            gate_pkg::PWR_DEEP: active_en = st_ff.deep_gate;
            default: active_en = st_ff.run_gate;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Read data mux
   // ------------------------------------------------------------
   always_comb begin
      rd_word = 32'h00000000;
      unique case (paddr)
         `DEEP_GATE_OFF: rd_word = to_word(st_ff.deep_gate);
         `RUN_GATE_OFF: rd_word = to_word(st_ff.run_gate);
         `SLEEP_GATE_OFF: rd_word = to_word(st_ff.sleep_gate);
         `CLK_CONFIG_OFF: rd_word[`SEL_BIT] = st_ff.sel;
         default: rd_word = 32'h00000000;
      endcase
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      // Read data is captured in setup so it is a flop in access
      if (setup_ph && !pwrite) begin
         nxt_st.prdata = rd_word;
      end
      if (wr_en) begin
         unique case (paddr)
            `DEEP_GATE_OFF: nxt_st.deep_gate = wr_gate;
            `RUN_GATE_OFF: nxt_st.run_gate = wr_gate;
            `SLEEP_GATE_OFF: nxt_st.sleep_gate = wr_gate;
            `CLK_CONFIG_OFF: nxt_st.sel = pwdata[`SEL_BIT];
            default: nxt_st.sel = st_ff.sel;
         endcase
      end
      // One cycle from register to gate keeps the enable glitch free
      nxt_st.unit_en = active_en;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff.run_gate <= `GATE_RESET_PACKED;
         st_ff.sleep_gate <= `GATE_RESET_PACKED;
         st_ff.deep_gate <= `GATE_RESET_PACKED;
         st_ff.sel <= 1'b0;
         st_ff.unit_en <= `GATE_RESET_PACKED;
         st_ff.prdata <= 32'h00000000;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign prdata = st_ff.prdata;
   assign pslverr = access_ph & ~addr_hit(paddr);
   assign unit_clk_en = st_ff.unit_en;
   // Unclocked unit cannot complete the access
   assign unit_fault = unit_access & |(unit_sel & ~st_ff.unit_en);

   genvar gi;
   generate
      for (gi = 0; gi < `NUM_UNITS; gi++) begin : g_gate
         glitch_free_gate u_gate (
            .clk_in(pclk),
            .enable(st_ff.unit_en[gi]),
            .clk_out(unit_clk[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic deep_written_ff;
   logic [31:0] deep_word;
   assign deep_word = to_word(st_ff.deep_gate);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         deep_written_ff <= 1'b0;
      end else if (wr_en && paddr == `DEEP_GATE_OFF) begin
         deep_written_ff <= 1'b1;
      end
   end

   sequence deep_wr_s;
      access_ph && pwrite && paddr == `DEEP_GATE_OFF;
   endsequence

   sequence deep_rd_s;
      setup_ph && !pwrite && paddr == `DEEP_GATE_OFF
      ##1 access_ph && !pwrite && paddr == `DEEP_GATE_OFF;
   endsequence

   property bit_follows_p(int b);
      deep_wr_s |=> deep_word[b] == $past(pwdata[b]);
   endproperty

   reset_value_a: assert property (
      !deep_written_ff |-> deep_word == `GATE_RESET)
      else $error("deep gate register lost reset value");

   keeper_bit_a: assert property (bit_follows_p(`KEEPER_BIT))
      else $error("keeper enable did not take write");

   fieldbus_bit_a: assert property (bit_follows_p(`FIELDBUS_BIT))
      else $error("fieldbus enable did not take write");

   pwm_bit_a: assert property (bit_follows_p(`PWM_BIT))
      else $error("pwm enable did not take write");

   conv_bit_a: assert property (bit_follows_p(`CONV_BIT))
      else $error("converter enable did not take write");

   watchdog_bit_a: assert property (bit_follows_p(`WATCHDOG_BIT))
      else $error("watchdog enable did not take write");

   reserved_zero_a: assert property (
      deep_rd_s |-> (prdata & ~`GATE_MASK) == 32'h00000000)
      else $error("reserved bits read nonzero");

   deep_decode_a: assert property (
      deep_rd_s |-> !pslverr && prdata == deep_word)
      else $error("deep gate register read wrong");

   clk_on_a: assert property (
      st_ff.sel && pwr == gate_pkg::PWR_DEEP && st_ff.deep_gate[4]
      ##1 st_ff.sel |-> unit_clk_en[4])
      else $error("enabled unit not clocked in deep sleep");

   clk_off_a: assert property (
      |active_en == 1'b0 |=> unit_clk_en == 5'h00)
      else $error("disabled unit still clocked");

   deep_select_a: assert property (
      st_ff.sel && pwr == gate_pkg::PWR_DEEP
      |=> unit_clk_en == $past(st_ff.deep_gate))
      else $error("deep sleep register not applied");

   run_only_a: assert property (
      !st_ff.sel |=> unit_clk_en == $past(st_ff.run_gate))
      else $error("run register not applied with select clear");

   fault_gate_a: assert property (
      unit_access && (unit_sel & ~unit_clk_en) != 5'h00 |-> unit_fault)
      else $error("access to unclocked unit not faulted");

   // ------------------------------------------------------------
   // Register map, source select and fault checks
   // ------------------------------------------------------------
   sequence bad_wr_s;
      access_ph && pwrite && !addr_hit(paddr);
   endsequence

   sequence reg_wr_s(logic [11:0] a);
      access_ph && pwrite && paddr == a;
   endsequence

   sequence reg_rd_s(logic [11:0] a);
      setup_ph && !pwrite && paddr == a
      ##1 access_ph && !pwrite && paddr == a;
   endsequence

   // One source per power state, applied one edge later
   property source_p(logic [1:0] s, logic [4:0] g);
      st_ff.sel && pwr_state == s |=> unit_clk_en == $past(g);
   endproperty

   run_read_a: assert property (
      reg_rd_s(`RUN_GATE_OFF)
      |-> !pslverr && prdata == to_word(st_ff.run_gate))
      else $error("run gate register read wrong");

   sleep_read_a: assert property (
      reg_rd_s(`SLEEP_GATE_OFF)
      |-> !pslverr && prdata == to_word(st_ff.sleep_gate))
      else $error("sleep gate register read wrong");

   select_read_a: assert property (
      reg_rd_s(`CLK_CONFIG_OFF)
      |-> !pslverr && prdata == {31'h00000000, st_ff.sel})
      else $error("select bit read wrong");

   run_write_a: assert property (
      reg_wr_s(`RUN_GATE_OFF)
      |=> to_word(st_ff.run_gate) == ($past(pwdata) & `GATE_MASK))
      else $error("run gate register did not take write");

   sleep_write_a: assert property (
      reg_wr_s(`SLEEP_GATE_OFF)
      |=> to_word(st_ff.sleep_gate) == ($past(pwdata) & `GATE_MASK))
      else $error("sleep gate register did not take write");

   select_write_a: assert property (
      reg_wr_s(`CLK_CONFIG_OFF)
      |=> st_ff.sel == $past(pwdata[`SEL_BIT]))
      else $error("select bit did not take write");

   deep_mask_a: assert property (
      deep_wr_s |=> deep_word == ($past(pwdata) & `GATE_MASK))
      else $error("reserved write bits were kept");

   misaligned_err_a: assert property (
      access_ph && paddr[1:0] != 2'b00 |-> pslverr)
      else $error("misaligned access not refused");

   mapped_ok_a: assert property (
      access_ph && paddr == `DEEP_GATE_OFF |-> pready && !pslverr)
      else $error("deep gate register access refused");

   bad_write_a: assert property (
      bad_wr_s |=> $stable(st_ff.deep_gate) && $stable(st_ff.run_gate)
      && $stable(st_ff.sleep_gate) && $stable(st_ff.sel))
      else $error("unmapped write changed a register");

   deep_hold_a: assert property (
      !(access_ph && pwrite && paddr == `DEEP_GATE_OFF)
      |=> $stable(st_ff.deep_gate))
      else $error("deep gate register changed without a write");

   read_hold_a: assert property (
      !(setup_ph && !pwrite) |=> $stable(prdata))
      else $error("read data moved outside a read");

   run_select_a: assert property (source_p(2'b00, st_ff.run_gate))
      else $error("run register not applied in run");

   sleep_select_a: assert property (source_p(2'b01, st_ff.sleep_gate))
      else $error("sleep register not applied in sleep");

   odd_state_a: assert property (source_p(2'b11, st_ff.run_gate))
      else $error("run register not applied for unused state");

   clk_withheld_a: assert property (
      st_ff.sel && pwr == gate_pkg::PWR_DEEP && !st_ff.deep_gate[4]
      |=> !unit_clk_en[4])
      else $error("cleared unit clocked in deep sleep");

   fault_clear_a: assert property (
      unit_access && (unit_sel & ~unit_clk_en) == 5'h00 |-> !unit_fault)
      else $error("access to clocked unit faulted");

   idle_fault_a: assert property (
      !unit_access |-> !unit_fault)
      else $error("fault raised with no access");

   // The cell holds last low-phase enable through the high phase
   gated_clk_a: assert property (
      @(negedge pclk) disable iff (!presetn)
      unit_clk == $past(unit_clk_en))
      else $error("gated clock does not follow latched enable");

endmodule : deep_sleep_clock_gate_reg0

// ---- bench/tb_top.sv ----
// Testbench for the deep-sleep clock gating registers
`timescale 1ns/1ps
`include "gate_defines.svh"
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [1:0] pwr_state = 2'h0;
   logic unit_access = 1'b0;
   logic [4:0] unit_sel = 5'h00;
   logic unit_fault;
   logic [4:0] unit_clk_en;
   logic [4:0] unit_clk;
   int n_fail = 0;
   int compares = 0;
   logic [31:0] rd;
   logic err;
   logic [11:0] offs [4] = '{`DEEP_GATE_OFF, `RUN_GATE_OFF,
      `SLEEP_GATE_OFF, `CLK_CONFIG_OFF};
   int pos [5] = '{3, 6, 16, 20, 24};
   logic [4:0] st_exp [4] = '{5'h01, 5'h08, 5'h10, 5'h01};

   always #12.5 pclk = ~pclk;

   deep_sleep_clock_gate_reg0 dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pwr_state(pwr_state),
      .unit_access(unit_access), .unit_sel(unit_sel),
      .unit_fault(unit_fault), .unit_clk_en(unit_clk_en),
      .unit_clk(unit_clk)
   );

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic tally_and_finish();
      $display("Counts: %0d compares, %0d failures", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask : chk

   // One APB transfer; a leading edge keeps drives one per time step
   task automatic apb(input logic wr, input logic [11:0] addr,
      input logic [31:0] wdata);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         $display("Error pready expected 1 seen %b", pready);
         n_fail++;
         tally_and_finish();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Enables land one edge after the cause; wait two edges and look at the falling edge
   task automatic settle();
      repeat (2) @(posedge pclk);
      @(negedge pclk);
   endtask : settle

   task automatic set_state(input logic [1:0] s);
      @(posedge pclk);
      pwr_state <= s;
      settle();
   endtask : set_state

   // Reset values of the effective enables and of all four registers
   task automatic check_reset();
      chk("reset enables", 32'h00000002, {27'h0000000, unit_clk_en});
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, offs[i], 32'h00000000);
         chk("reset word", (i == 3) ? 32'h0 : 32'h00000040, rd);
      end
      $display("Test reset values done");
   endtask : check_reset

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      check_reset();
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, offs[i], 32'hFFFFFFFF);
         apb(1'b0, offs[i], 32'h00000000);
         chk("ones readback", (i == 3) ? 32'h1 : 32'h01110048, rd);
         chk("mapped err", 32'h0, {31'h0, err});
      end
      apb(1'b1, `DEEP_GATE_OFF, 32'hFEEEFFB7);
      apb(1'b0, `DEEP_GATE_OFF, 32'h00000000);
      chk("reserved bits", 32'h00000000, rd);
      apb(1'b0, 12'h122, 32'h00000000);
      chk("misaligned err", 32'h1, {31'h0, err});
      apb(1'b1, 12'h130, 32'hFFFFFFFF);
      chk("unmapped write err", 32'h1, {31'h0, err});
      apb(1'b0, 12'h130, 32'h00000000);
      chk("unmapped read err", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      apb(1'b0, `DEEP_GATE_OFF, 32'h00000000);
      chk("deep kept", 32'h00000000, rd);
      $display("Test register access done");
      apb(1'b1, `RUN_GATE_OFF, 32'h00000008);
      apb(1'b1, `SLEEP_GATE_OFF, 32'h00100000);
      apb(1'b1, `DEEP_GATE_OFF, 32'h01000000);
      apb(1'b1, `CLK_CONFIG_OFF, 32'h00000000);
      set_state(2'h2);
      chk("no select", 32'h1, {27'h0000000, unit_clk_en});
      apb(1'b1, `CLK_CONFIG_OFF, 32'h00000001);
      for (int s = 0; s < 4; s++) begin
         set_state(s[1:0]);
         chk("state source", {27'h0, st_exp[s]}, {27'h0, unit_clk_en});
      end
      $display("Test state select done");
      // Deep-sleep source must be selected for the deep register to act
      set_state(2'h2);
      for (int b = 0; b < 5; b++) begin
         apb(1'b1, `DEEP_GATE_OFF, 32'h00000001 << pos[b]);
         settle();
         chk("unit enable", 32'h1 << b, {27'h0, unit_clk_en});
         @(posedge pclk);
         #2;
         chk("unit clock high", 32'h1 << b, {27'h0, unit_clk});
         @(negedge pclk);
         #2;
         chk("unit clock low", 32'h0, {27'h0, unit_clk});
         for (int s = 0; s < 5; s++) begin
            @(posedge pclk);
            unit_access <= 1'b1;
            unit_sel <= 5'h01 << s;
            @(negedge pclk);
            chk("fault", (s == b) ? 32'h0 : 32'h1, {31'h0, unit_fault});
         end
         @(posedge pclk);
         unit_access <= 1'b0;
      end
      $display("Test unit gating done");
      // Second reset in mid-run must restore every register
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      check_reset();
      tally_and_finish();
   end
endmodule : tb_top
